// File: bosr_map.svh
`ifndef BOSR_MAP_SVH
`define BOSR_MAP_SVH

// register byte offsets
`define BOSR_OFF_RASTER_CTRL  19'h00000
`define BOSR_OFF_DEST_SIZE    19'h00004
`define BOSR_OFF_PAT_ADDR     19'h00008
`define BOSR_OFF_PAT_BG       19'h40040
`define BOSR_OFF_PAT_FG       19'h0000C
`define BOSR_OFF_SRC_BG       19'h00010
`define BOSR_OFF_SRC_FG       19'h00014
`define BOSR_OFF_DEST_ADDR    19'h00018
`define BOSR_OFF_STATUS       19'h0001C
`define BOSR_OFF_OPCODE       19'h00020
`define BOSR_OFF_PAT_BG_LOAD  19'h00024

// control word fields
`define BOSR_SOLID_BIT        31
`define BOSR_CLIP_BIT         30
`define BOSR_SRC_TRANS_BIT    29
`define BOSR_PAT_TRANS_BIT    28
`define BOSR_DEPTH_HI         25
`define BOSR_DEPTH_LO         24
`define BOSR_ROP_HI           23
`define BOSR_ROP_LO           16
`define BOSR_PITCH_HI         15
`define BOSR_PITCH_LO         0

// size fields
`define BOSR_HEIGHT_HI        28
`define BOSR_HEIGHT_LO        16
`define BOSR_WIDTH_HI         12
`define BOSR_WIDTH_LO         0

// pattern and destination address fields
`define BOSR_PADDR_HI         28
`define BOSR_PADDR_LO         6
`define BOSR_DADDR_HI         28

// opcode bits and reset values
`define BOSR_OPC_MONO_SRC     0
`define BOSR_OPC_MONO_PAT     1
`define BOSR_RST_WORD         32'h0000_0000

`endif

// File: bosr_pkg.sv
package bosr_pkg;
    typedef enum logic [1:0] {
        BOSR_DEPTH_8,
        BOSR_DEPTH_16,
        BOSR_DEPTH_32,
        BOSR_DEPTH_RSVD
    } bosr_depth_t;

    typedef enum logic [1:0] {
        BOSR_ST_IDLE,
        BOSR_ST_PIXEL,
        BOSR_ST_LINE_END
    } bosr_state_t;
endpackage : bosr_pkg

// File: bosr_regs.sv
//
// Overview of operation
// - Control bit 30 set enables destination clipping; clear means no clipping.
// - Mono source, transparency off: zero source bit uses source background colour.
// - Mono source, transparency on: zero source bit leaves destination bytes unwritten.
// - Mono pattern, transparency off: zero pattern bit uses pattern background colour.
// - Mono pattern, transparency on: zero pattern bit suppresses destination write.
// - Transparency applies only to operands the opcode declares monochrome.
// - Depth field 25:24: 00 8-bit, 01 16-bit, 10 next depth, 11 reserved.
// - Bits 23:16 select one of 256 raster operations over source, pattern, destination.
// - After each line, destination address advances by signed 16-bit pitch.
// - Destination height is a 13-bit working line count.
// - Destination width bits 12:0 count bytes per line; pixels follow depth.
// - Pattern start address is the 23-bit field 28:6, in linear memory.
// - Pattern address bits 5:0 read as zero.
// - Mono pattern expansion uses pattern background and foreground registers.
// - Expansion colours use low 8, 16 or all 32 bits by depth.
// - Source background also serves as the destination transparency compare colour.
// - Mono source expansion foreground comes from source foreground register.
// - Solid pattern bit, with the opcode declaring a mono pattern, forces pattern bits zero and pattern operand background.
// - Writing destination address register last starts the operation.
`timescale 1ns/1ps
`default_nettype none
`include "bosr_map.svh"

module bosr_regs (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    // axi4-lite write address
    input  wire logic [18:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [18:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // monochrome operand stream, one bit per pixel
    input  wire logic        MONO_SRC_BIT,
    input  wire logic        MONO_PAT_BIT,
    input  wire logic        PIX_VALID,
    output logic             PIX_READY,
    // expanded operands and write control
    output logic [31:0]      SRC_OPERAND,
    output logic [31:0]      PAT_OPERAND,
    output logic             DEST_WRITE_EN,
    output logic             PAT_FETCH_EN,
    output logic             CLIP_ENABLE,
    output logic [7:0]       RASTER_OP_CODE,
    output logic [28:0]      DEST_LINE_ADDR,
    output logic [31:0]      DEST_COMPARE_COLOR,
    output logic             ENGINE_BUSY
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [31:0]               raster_control_reg;
    logic [31:0]               dest_size_reg;
    logic [31:0]               pattern_address_reg;
    logic [31:0]               pattern_bg_reg;
    logic [31:0]               pattern_fg_reg;
    logic [31:0]               source_bg_reg;
    logic [31:0]               source_fg_reg;
    logic [28:0]               destination_address_reg;
    logic [1:0]                opcode_reg;
    logic [12:0]               bytes_left;
    bosr_pkg::bosr_state_t     state;
    logic [18:0] aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic        wr_fire;
    logic        wr_hit;
    logic        start;
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // ----------------------------------------------------------------
    // write channel: address and data taken in either order
    // ----------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
    assign wr_fire       = aw_held && w_held;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            aw_held <= 1'b0;
            aw_addr <= 19'h00000;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end
    always_comb begin
        unique case (aw_addr)
            `BOSR_OFF_RASTER_CTRL, `BOSR_OFF_DEST_SIZE, `BOSR_OFF_PAT_ADDR, `BOSR_OFF_PAT_FG,
            `BOSR_OFF_SRC_BG, `BOSR_OFF_SRC_FG, `BOSR_OFF_DEST_ADDR, `BOSR_OFF_OPCODE,
            `BOSR_OFF_PAT_BG_LOAD: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // a write while busy is still stored; software owns ordering
    assign start = wr_fire && aw_addr == `BOSR_OFF_DEST_ADDR;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= 2'b00;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? 2'b00 : 2'b10;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            raster_control_reg  <= `BOSR_RST_WORD;
            pattern_address_reg <= `BOSR_RST_WORD;
            pattern_bg_reg      <= `BOSR_RST_WORD;
            pattern_fg_reg      <= `BOSR_RST_WORD;
            source_bg_reg       <= `BOSR_RST_WORD;
            source_fg_reg       <= `BOSR_RST_WORD;
            opcode_reg          <= 2'b00;
        end else if (wr_fire) begin
            unique case (aw_addr)
                `BOSR_OFF_RASTER_CTRL:  raster_control_reg <= merge(raster_control_reg, w_data, w_strb);
                `BOSR_OFF_PAT_ADDR:     pattern_address_reg <= merge(pattern_address_reg, w_data, w_strb)
                                                           & 32'h1FFF_FFC0;
                // pattern background is read-only on the bus; loaded through an alias
                `BOSR_OFF_PAT_BG_LOAD:  pattern_bg_reg <= merge(pattern_bg_reg, w_data, w_strb);
                `BOSR_OFF_PAT_FG:       pattern_fg_reg <= merge(pattern_fg_reg, w_data, w_strb);
                `BOSR_OFF_SRC_BG:       source_bg_reg  <= merge(source_bg_reg, w_data, w_strb);
                `BOSR_OFF_SRC_FG:       source_fg_reg  <= merge(source_fg_reg, w_data, w_strb);
                `BOSR_OFF_OPCODE:       opcode_reg     <= w_data[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // operand expansion
    // ----------------------------------------------------------------
    bosr_pkg::bosr_depth_t depth;
    logic [31:0]           lane_mask;
    logic                  mono_src;
    logic                  mono_pat;
    logic                  solid;
    logic                  pat_bit;
    logic                  src_skip;
    logic                  pat_skip;
    logic                  pix_fire;
    logic                  line_done;

    assign depth    = bosr_pkg::bosr_depth_t'(raster_control_reg[`BOSR_DEPTH_HI:`BOSR_DEPTH_LO]);
    assign mono_src = opcode_reg[`BOSR_OPC_MONO_SRC];
    assign mono_pat = opcode_reg[`BOSR_OPC_MONO_PAT];
    assign solid    = mono_pat && raster_control_reg[`BOSR_SOLID_BIT];

    always_comb begin
        unique case (depth)
            bosr_pkg::BOSR_DEPTH_8:  lane_mask = 32'h0000_00FF;
            bosr_pkg::BOSR_DEPTH_16: lane_mask = 32'h0000_FFFF;
            bosr_pkg::BOSR_DEPTH_32: lane_mask = 32'hFFFF_FFFF;
            bosr_pkg::BOSR_DEPTH_RSVD: lane_mask = 32'h0000_0000;
        endcase
    end

    assign pat_bit  = solid ? 1'b0 : MONO_PAT_BIT;
    // transparency only counts for monochrome operands
    assign src_skip = mono_src && raster_control_reg[`BOSR_SRC_TRANS_BIT] && !MONO_SRC_BIT;
    assign pat_skip = mono_pat && raster_control_reg[`BOSR_PAT_TRANS_BIT] && !pat_bit;
    assign pix_fire = PIX_VALID && PIX_READY;
    assign PIX_READY = state == bosr_pkg::BOSR_ST_PIXEL;
    assign PAT_FETCH_EN = !solid;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            SRC_OPERAND   <= 32'h0000_0000;
            PAT_OPERAND   <= 32'h0000_0000;
            DEST_WRITE_EN <= 1'b0;
        end else begin
            DEST_WRITE_EN <= pix_fire && !src_skip && !pat_skip;
            if (pix_fire) begin
                SRC_OPERAND <= (MONO_SRC_BIT ? source_fg_reg : source_bg_reg) & lane_mask;
                PAT_OPERAND <= (pat_bit ? pattern_fg_reg : pattern_bg_reg) & lane_mask;
            end
        end
    end

    assign CLIP_ENABLE        = raster_control_reg[`BOSR_CLIP_BIT];
    assign RASTER_OP_CODE     = raster_control_reg[`BOSR_ROP_HI:`BOSR_ROP_LO];
    assign DEST_COMPARE_COLOR = source_bg_reg & lane_mask;
    assign DEST_LINE_ADDR     = destination_address_reg;
    assign ENGINE_BUSY        = state != bosr_pkg::BOSR_ST_IDLE;

    // ----------------------------------------------------------------
    // scan line walk
    // ----------------------------------------------------------------
    logic [12:0] width_bytes;
    logic [12:0] step_bytes;
    logic [28:0] pitch_ext;

    assign width_bytes = dest_size_reg[`BOSR_WIDTH_HI:`BOSR_WIDTH_LO];
    assign pitch_ext   = {{13{raster_control_reg[`BOSR_PITCH_HI]}},
                          raster_control_reg[`BOSR_PITCH_HI:`BOSR_PITCH_LO]};

    always_comb begin
        unique case (depth)
            bosr_pkg::BOSR_DEPTH_16: step_bytes = 13'h0002;
            bosr_pkg::BOSR_DEPTH_32: step_bytes = 13'h0004;
            default:                 step_bytes = 13'h0001;
        endcase
    end

    assign line_done = pix_fire && bytes_left <= step_bytes;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state <= bosr_pkg::BOSR_ST_IDLE;
        end else begin
            unique case (state)
                bosr_pkg::BOSR_ST_IDLE: begin
                    if (start && width_bytes != 13'h0000 && dest_size_reg[`BOSR_HEIGHT_HI:`BOSR_HEIGHT_LO] != 13'h0000) begin
                        state <= bosr_pkg::BOSR_ST_PIXEL;
                    end
                end
                bosr_pkg::BOSR_ST_PIXEL: begin
                    if (line_done) begin
                        state <= bosr_pkg::BOSR_ST_LINE_END;
                    end
                end
                bosr_pkg::BOSR_ST_LINE_END: begin
                    if (dest_size_reg[`BOSR_HEIGHT_HI:`BOSR_HEIGHT_LO] == 13'h0000) begin
                        state <= bosr_pkg::BOSR_ST_IDLE;
                    end else begin
                        state <= bosr_pkg::BOSR_ST_PIXEL;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            bytes_left <= 13'h0000;
        end else if (start || state == bosr_pkg::BOSR_ST_LINE_END) begin
            bytes_left <= width_bytes;
        end else if (pix_fire) begin
            bytes_left <= bytes_left - step_bytes;
        end
    end

    // height counts down as lines complete
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            dest_size_reg <= `BOSR_RST_WORD;
        end else if (wr_fire && aw_addr == `BOSR_OFF_DEST_SIZE) begin
            dest_size_reg <= merge(dest_size_reg, w_data, w_strb) & 32'h1FFF_1FFF;
        end else if (line_done) begin
            dest_size_reg[`BOSR_HEIGHT_HI:`BOSR_HEIGHT_LO] <=
                dest_size_reg[`BOSR_HEIGHT_HI:`BOSR_HEIGHT_LO] - 13'h0001;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            destination_address_reg <= 29'h0000_0000;
        end else if (start) begin
            destination_address_reg <= w_data[`BOSR_DADDR_HI:0];
        end else if (line_done) begin
            destination_address_reg <= destination_address_reg + pitch_ext;
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    logic [31:0] rd_word;
    logic        rd_hit;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (S_AXI_ARADDR)
            `BOSR_OFF_RASTER_CTRL: rd_word = raster_control_reg;
            `BOSR_OFF_DEST_SIZE:   rd_word = dest_size_reg;
            `BOSR_OFF_PAT_ADDR:    rd_word = pattern_address_reg;
            `BOSR_OFF_PAT_BG:      rd_word = pattern_bg_reg;
            `BOSR_OFF_PAT_FG:      rd_word = pattern_fg_reg;
            `BOSR_OFF_SRC_BG:      rd_word = source_bg_reg;
            `BOSR_OFF_SRC_FG:      rd_word = source_fg_reg;
            `BOSR_OFF_DEST_ADDR:   rd_word = {3'b000, destination_address_reg};
            `BOSR_OFF_STATUS:      rd_word = {31'h0000_0000, ENGINE_BUSY};
            `BOSR_OFF_OPCODE:      rd_word = {30'h0000_0000, opcode_reg};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= 2'b00;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_word;
            S_AXI_RRESP  <= rd_hit ? 2'b00 : 2'b10;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_start_walk: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        start && state == bosr_pkg::BOSR_ST_IDLE && width_bytes != 13'h0000
        && dest_size_reg[28:16] != 13'h0000 |=> state == bosr_pkg::BOSR_ST_PIXEL)
        else $error("walk did not start on destination address write");
    a_pitch_step: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        line_done && !start |=> destination_address_reg == $past(destination_address_reg) + $past(pitch_ext))
        else $error("destination address did not advance by pitch");
    a_height_dec: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        line_done && !(wr_fire && aw_addr == `BOSR_OFF_DEST_SIZE)
        |=> dest_size_reg[28:16] == $past(dest_size_reg[28:16]) - 13'h0001)
        else $error("height count did not decrement");
    a_src_trans: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        pix_fire && mono_src && raster_control_reg[29] && !MONO_SRC_BIT |=> !DEST_WRITE_EN)
        else $error("transparent source pixel was written");
    a_pat_trans: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        pix_fire && pat_skip |=> !DEST_WRITE_EN)
        else $error("transparent pattern pixel was written");
    a_src_expand: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        pix_fire && !MONO_SRC_BIT |=> SRC_OPERAND == $past(source_bg_reg & lane_mask))
        else $error("zero source bit not expanded to background");
    a_pat_solid: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        pix_fire && solid |=> PAT_OPERAND == $past(pattern_bg_reg & lane_mask))
        else $error("solid pattern not forced to background");
    a_paddr_low: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        S_AXI_RVALID && $past(S_AXI_ARADDR) == `BOSR_OFF_PAT_ADDR && $rose(S_AXI_RVALID)
        |-> S_AXI_RDATA[5:0] == 6'h00)
        else $error("pattern address low bits not zero");
    a_fg_lane8: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        pix_fire && depth == bosr_pkg::BOSR_DEPTH_8 |=> PAT_OPERAND[31:8] == 24'h000000)
        else $error("8-bit depth leaked upper lanes");
    c_walk:    cover property (@(posedge REF_CLK) state == bosr_pkg::BOSR_ST_LINE_END);
    c_skip:    cover property (@(posedge REF_CLK) pix_fire && src_skip);
    c_neg:     cover property (@(posedge REF_CLK) line_done && pitch_ext[28]);
    c_bad_rd:  cover property (@(posedge REF_CLK) S_AXI_RVALID && S_AXI_RRESP == 2'b10);
endmodule : bosr_regs
`default_nettype wire

// File: bosr_pix_src.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------
// monochrome pixel source feeding the operand stream
// ----------------------------------------------
module bosr_pix_src (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pixel handshake
    input  wire logic ready,
    output logic      valid,
    output logic      src_bit,
    output logic      pat_bit
);
    integer seed = 57;

    // offer held until taken; idle bits keep changing so stale data never looks valid
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid <= 1'b0;
            src_bit <= 1'b0;
            pat_bit <= 1'b0;
        end else if (!valid || ready) begin
            valid <= ($random(seed) & 3) != 0;
            src_bit <= ($random(seed) & 1) != 0;
            pat_bit <= ($random(seed) & 1) != 0;
        end
    end
endmodule : bosr_pix_src

`default_nettype wire

// File: test_blit_operand_state_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "bosr_map.svh"

module test_blit_operand_state_registers;
    logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [18:0] awa = 19'h00000, ara = 19'h00000;
    logic [31:0] wd = 32'h0, ctrl, sfg, sbg, pfg, pbg, m;
    logic [3:0]  ws = 4'h0;
    logic [28:0] da;
    logic [1:0]  opc;
    logic        pend = 1'b0, pbe;
    logic [66:0] e;
    logic [33:0] rq[$];
    logic [66:0] pq[$];
    wire logic   awr, wr_, bv, arr, rv, pv, pr, sb, pb, dwe, pfe, clip, busy;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata, sop, pop, dcc;
    wire logic [7:0]  raster_op_code;
    wire logic [28:0] dla;
    integer      seed = 57, mismatches = 0, checks = 0, cyc = 0, npix = 0, i, h;

    bosr_regs dut (.REF_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .MONO_SRC_BIT(sb),
        .MONO_PAT_BIT(pb), .PIX_VALID(pv), .PIX_READY(pr), .SRC_OPERAND(sop), .PAT_OPERAND(pop),
        .DEST_WRITE_EN(dwe), .PAT_FETCH_EN(pfe), .CLIP_ENABLE(clip), .RASTER_OP_CODE(raster_op_code),
        .DEST_LINE_ADDR(dla), .DEST_COMPARE_COLOR(dcc), .ENGINE_BUSY(busy));

    bosr_pix_src src (.clk(clk), .rst_n(rst_n), .ready(pr), .valid(pv), .src_bit(sb), .pat_bit(pb));

    initial begin
        forever #25 clk = ~clk;
    end

    // ----------------------------------------------
    // bus tasks and comparison
    // ----------------------------------------------
    task automatic chk(input string n, input logic [33:0] x, input logic [33:0] v);
        checks++;
        if (x !== v) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, x, v);
        end
    endtask : chk

    task end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task wr(input logic [18:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        @(posedge clk);
        while (awv && !awr || wv && !wr_) begin
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
            @(posedge clk);
        end
        awv <= 1'b0;
        wv <= 1'b0;
        br <= 1'b1;
        do @(posedge clk); while (!bv);
        br <= 1'b0;
        chk("bresp", r, bresp);
    endtask : wr

    task rd(input logic [18:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        rr <= 1'b1;
        do @(posedge clk); while (!rv);
        rr <= 1'b0;
    endtask : rd

    // ----------------------------------------------
    // result watcher
    // ----------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rv && rr) chk("rdata", rq.pop_front(), {rresp, rdata});
        if (pend) begin
            e = pq.pop_front();
            chk("write_en", e[64], dwe);
            if (e[66]) chk("src_operand", e[63:32], sop);
            if (e[65]) chk("pat_operand", e[31:0], pop);
        end
        pend <= pv && pr;
        if (pv && pr) begin
            npix++;
            pbe = pb && !(ctrl[31] && opc[1]);
            pq.push_back({opc[0], opc[1], !((opc[0] && ctrl[29] && !sb) || (opc[1] && ctrl[28] && !pbe)),
                (sb ? sfg : sbg) & m, (pbe ? pfg : pbg) & m});
        end
        if (cyc > 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`BOSR_OFF_RASTER_CTRL, 32'h0, 2'h0);
        wr(`BOSR_OFF_PAT_ADDR, 32'hFFFFFFFF, 4'hF, 2'h0);
        rd(`BOSR_OFF_PAT_ADDR, 32'h1FFFFFC0, 2'h0);
        wr(`BOSR_OFF_DEST_SIZE, 32'hFFFFFFFF, 4'hF, 2'h0);
        rd(`BOSR_OFF_DEST_SIZE, 32'h1FFF1FFF, 2'h0);
        wr(`BOSR_OFF_PAT_BG, 32'h12345678, 4'hF, 2'h2);
        wr(`BOSR_OFF_PAT_BG_LOAD, 32'hA5C35A3C, 4'hF, 2'h0);
        rd(`BOSR_OFF_PAT_BG, 32'hA5C35A3C, 2'h0);
        wr(`BOSR_OFF_SRC_FG, 32'h11223344, 4'hF, 2'h0);
        wr(`BOSR_OFF_SRC_FG, 32'h000000AA, 4'h1, 2'h0);
        rd(`BOSR_OFF_SRC_FG, 32'h112233AA, 2'h0);
        rd(19'h00100, 32'h0, 2'h2);
        $display("register test done");
        for (i = 0; i < 8; i++) begin
            ctrl = $random(seed);
            ctrl[27:24] = {2'h0, i[1:0]};
            opc = (i < 5) ? 2'h3 : i[1:0] - 2'h1;
            if (i == 0) ctrl[23:16] = 8'hF0;
            if (!opc[0] && ctrl[23:16] == 8'hF0) ctrl[16] = 1'b1;
            m = {{16{i[1:0] == 2}}, {8{i[1:0] == 1 || i[1:0] == 2}}, {8{i[1:0] != 3}}};
            h = 1 + i % 3;
            sfg = $random(seed);
            sbg = $random(seed);
            pfg = $random(seed);
            pbg = $random(seed);
            da = 29'($random(seed));
            wr(`BOSR_OFF_RASTER_CTRL, ctrl, 4'hF, 2'h0);
            wr(`BOSR_OFF_DEST_SIZE, {3'h0, h[12:0], 16'h0008}, 4'hF, 2'h0);
            wr(`BOSR_OFF_PAT_FG, pfg, 4'hF, 2'h0);
            wr(`BOSR_OFF_SRC_BG, sbg, 4'hF, 2'h0);
            wr(`BOSR_OFF_SRC_FG, sfg, 4'hF, 2'h0);
            wr(`BOSR_OFF_PAT_BG_LOAD, pbg, 4'hF, 2'h0);
            wr(`BOSR_OFF_PAT_ADDR, {da[22:0], 9'h000}, 4'hF, 2'h0);
            rd(`BOSR_OFF_PAT_ADDR, {3'h0, da[19:0], 9'h000}, 2'h0);
            wr(`BOSR_OFF_OPCODE, {30'h0, opc}, 4'hF, 2'h0);
            npix = 0;
            wr(`BOSR_OFF_DEST_ADDR, {3'h0, da}, 4'hF, 2'h0);
            chk("busy", 1'b1, busy);
            chk("clip", ctrl[30], clip);
            chk("rop", ctrl[23:16], raster_op_code);
            chk("cmp_color", sbg & m, dcc);
            chk("pat_fetch", !(ctrl[31] && opc[1]), pfe);
            while (busy) @(posedge clk);
            chk("pixels", h * (i[1:0] == 1 ? 4 : i[1:0] == 2 ? 2 : 8), npix);
            chk("dest_addr", 29'(da + h * {{16{ctrl[15]}}, ctrl[15:0]}), dla);
            $display("blit %0d done", i);
        end
        end_sim();
    end
endmodule : test_blit_operand_state_registers

`default_nettype wire
